// ==== rtl/cfs_pkg.sv ====
// Constants and types for the CPU flag and stack register block
`default_nettype none
package cfs_pkg;
	// ----------------------------------------------------------------
	// Condition code layout
	// ----------------------------------------------------------------
	localparam int CC_CARRY_BIT = 0;
	localparam int CC_ZERO_BIT = 1;
	localparam int CC_NEG_BIT = 2;
	localparam int CC_MASK_LO_BIT = 3;
	localparam int CC_HALF_BIT = 4;
	localparam int CC_MASK_HI_BIT = 5;
	localparam logic [7:0] CC_FIXED_ONES = 8'hC0;
	localparam logic [7:0] CC_RESET = 8'hE8;
	// ----------------------------------------------------------------
	// Stack pointer
	// ----------------------------------------------------------------
	localparam logic [15:0] SP_RESET = 16'h017F;
	localparam logic [15:0] SP_FIXED = 16'h0100;
	localparam int SP_LOW_BITS = 7;
	localparam int CALL_BYTES = 2;
	localparam int IRQ_BYTES = 5;
	// ----------------------------------------------------------------
	// Priority mask encodings (upper, lower)
	// ----------------------------------------------------------------
	localparam logic [1:0] LEVEL0 = 2'h2;
	localparam logic [1:0] LEVEL1 = 2'h1;
	localparam logic [1:0] LEVEL2 = 2'h0;
	localparam logic [1:0] LEVEL3 = 2'h3;
	// ----------------------------------------------------------------
	// Operations
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_NONE   = 4'h0,
		OP_ADD    = 4'h1,
		OP_RESULT = 4'h2,
		OP_ARITH  = 4'h3,
		OP_SHIFT  = 4'h4,
		OP_SETC   = 4'h5,
		OP_CLRC   = 4'h6,
		OP_MASKR  = 4'h7,
		OP_MASKA  = 4'h8,
		OP_CCPOP  = 4'h9,
		OP_SPRST  = 4'hA,
		OP_SPLOAD = 4'hB,
		OP_PCLOAD = 4'hC,
		OP_PCINC  = 4'hD
	} cfs_op_type;
	typedef enum logic [6:0] {
		ST_IDLE  = 7'h01,
		ST_PUSH  = 7'h02,
		ST_POP   = 7'h04,
		ST_CALL  = 7'h08,
		ST_RET   = 7'h10,
		ST_IRQ   = 7'h20,
		ST_HANDLER_RETURN_OP  = 7'h40
	} cfs_state_type;
endpackage
`default_nettype wire

// ==== rtl/cfs_regs.sv ====
// CPU condition code, program counter and stack sequencing
// Functional notes
// RQ1: Half carry at bit 4 follows carry from bit 3 on add operations.
// RQ2: Negative flag at bit 2 copies result bit 7.
// RQ3: Zero flag at bit 1 set when result is zero.
// RQ4: Carry at bit 0 from arithmetic, set/clear, test, shift and rotate.
// RQ5: Mask bits 5 and 3 encode levels 10,01,00,11.
// RQ6: Interrupt entry loads mask from vector priority; mask ops also change it.
// RQ7: Condition code pushes and pops as a whole byte.
// RQ8: Pointer names next free byte; decrement after push, increment before pop.
// RQ9: Upper nine pointer bits fixed; reset and reinit load 017Fh.
// RQ10: Pointer wraps silently at both stack limits.
// RQ11: Interrupt stacks program counter low byte first, rest lower.
// RQ12: Call uses two stack bytes, interrupt five.
// RQ13: Second index register untouched by interrupt entry and return.
// RQ14: Program counter is low and high byte registers.
// RQ15: Stack pointer low byte loadable and readable directly.
// RQ16: Interrupt stacks PC, X, A, CC; return restores all, mask included.
// RQ17: Unassigned condition code bits read as one, ignore writes.
`default_nettype none
module cfs_regs (
	input  wire logic              mclk,
	input  wire logic              resetn,
	input  wire cfs_pkg::cfs_op_type op,
	input  wire logic [7:0]        result,
	input  wire logic              alu_carry,
	input  wire logic              alu_half,
	input  wire logic [7:0]        op_data,
	input  wire logic [15:0]       pc_value,
	input  wire logic              push_req,
	input  wire logic              pop_req,
	input  wire logic              call_req,
	input  wire logic              ret_req,
	input  wire logic              irq_req,
	input  wire logic              handler_return_op_req,
	input  wire logic [1:0]        vector_priority_setting,
	input  wire logic [15:0]       vector_addr,
	input  wire logic [7:0]        x_value,
	input  wire logic [7:0]        a_value,
	input  wire logic [7:0]        stack_rdata,
	output logic      [7:0]        condition_code,
	output logic      [7:0]        prog_counter_low_byte,
	output logic      [7:0]        prog_counter_high_byte,
	output logic      [15:0]       stack_pointer,
	output logic      [15:0]       stack_addr,
	output logic      [7:0]        stack_wdata,
	output logic                   stack_we,
	output logic                   stack_re,
	output logic      [7:0]        x_restore,
	output logic      [7:0]        a_restore,
	output logic                   xa_restore_valid,
	output logic                   busy
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	cfs_pkg::cfs_state_type state_q, state_d;
	logic [2:0]  cnt_q, cnt_d;
	logic [7:0]  cc_q, cc_d;
	logic [15:0] pc_q, pc_d;
	logic [7:0]  x_q, x_d, a_q, a_d;
	logic        xav_q, xav_d;
	logic [15:0] addr_q, addr_d;
	logic [7:0]  wdata_q, wdata_d;
	logic        we_q, we_d, re_q, re_d;
	logic        busy_q, busy_d;
	logic        sp_dec, sp_inc, sp_reinit, sp_load;
	logic [15:0] sp;
	logic [15:0] sp_next_up;
	logic [7:0]  stack_snap [0:4];

	cfs_stack_ptr u_sp (
		.mclk       (mclk),
		.resetn     (resetn),
		.reinit     (sp_reinit),
		.load       (sp_load),
		.load_value (op_data),
		.dec        (sp_dec),
		.inc        (sp_inc),
		.sp         (sp)
	);

	assign sp_next_up = cfs_pkg::SP_FIXED | {9'h000, sp[6:0] + 7'h01};

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		cc_d = cc_q;
		pc_d = pc_q;
		x_d = x_q;
		a_d = a_q;
		xav_d = 1'b0;
		addr_d = addr_q;
		wdata_d = wdata_q;
		we_d = 1'b0;
		re_d = 1'b0;
		sp_dec = 1'b0;
		sp_inc = 1'b0;
		sp_reinit = 1'b0;
		sp_load = 1'b0;
		case (state_q)
			cfs_pkg::ST_IDLE: begin
				case (op)
					cfs_pkg::OP_ADD: begin
						cc_d[cfs_pkg::CC_HALF_BIT] = alu_half; // RQ1
						cc_d[cfs_pkg::CC_CARRY_BIT] = alu_carry; // RQ4
						cc_d[cfs_pkg::CC_NEG_BIT] = result[7]; // RQ2
						cc_d[cfs_pkg::CC_ZERO_BIT] = (result == 8'h00); // RQ3
					end
					cfs_pkg::OP_ARITH: begin
						cc_d[cfs_pkg::CC_CARRY_BIT] = alu_carry; // RQ4
						cc_d[cfs_pkg::CC_NEG_BIT] = result[7]; // RQ2
						cc_d[cfs_pkg::CC_ZERO_BIT] = (result == 8'h00); // RQ3
					end
					cfs_pkg::OP_RESULT: begin
						cc_d[cfs_pkg::CC_NEG_BIT] = result[7]; // RQ2
						cc_d[cfs_pkg::CC_ZERO_BIT] = (result == 8'h00); // RQ3
					end
					cfs_pkg::OP_SHIFT: cc_d[cfs_pkg::CC_CARRY_BIT] = alu_carry; // RQ4
					cfs_pkg::OP_SETC:  cc_d[cfs_pkg::CC_CARRY_BIT] = 1'b1; // RQ4
					cfs_pkg::OP_CLRC:  cc_d[cfs_pkg::CC_CARRY_BIT] = 1'b0; // RQ4
					cfs_pkg::OP_MASKR: begin
						cc_d[cfs_pkg::CC_MASK_HI_BIT] = cfs_pkg::LEVEL0[1]; // RQ6
						cc_d[cfs_pkg::CC_MASK_LO_BIT] = cfs_pkg::LEVEL0[0]; // RQ6
					end
					cfs_pkg::OP_MASKA: begin
						cc_d[cfs_pkg::CC_MASK_HI_BIT] = cfs_pkg::LEVEL3[1]; // RQ6
						cc_d[cfs_pkg::CC_MASK_LO_BIT] = cfs_pkg::LEVEL3[0]; // RQ6
					end
					cfs_pkg::OP_CCPOP: cc_d = op_data | cfs_pkg::CC_FIXED_ONES; // RQ7 RQ17
					cfs_pkg::OP_SPRST: sp_reinit = 1'b1; // RQ9
					cfs_pkg::OP_SPLOAD: sp_load = 1'b1; // RQ15
					cfs_pkg::OP_PCLOAD: pc_d = pc_value; // RQ14
					cfs_pkg::OP_PCINC: pc_d = pc_q + 16'h0001; // RQ14
					default: begin
					end
				endcase
				if (irq_req) begin
					state_d = cfs_pkg::ST_IRQ;
					cnt_d = 3'h0;
				end else if (handler_return_op_req) begin
					state_d = cfs_pkg::ST_HANDLER_RETURN_OP;
					cnt_d = 3'h0;
				end else if (call_req) begin
					state_d = cfs_pkg::ST_CALL;
					cnt_d = 3'h0;
				end else if (ret_req) begin
					state_d = cfs_pkg::ST_RET;
					cnt_d = 3'h0;
				end else if (push_req) begin
					// Write at next free location, then decrement
					addr_d = sp; // RQ8
					wdata_d = op_data;
					we_d = 1'b1;
					sp_dec = 1'b1; // RQ8
				end else if (pop_req) begin
					// Increment first, then read
					addr_d = sp_next_up; // RQ8
					re_d = 1'b1;
					sp_inc = 1'b1; // RQ8
					state_d = cfs_pkg::ST_POP;
				end
			end
			cfs_pkg::ST_POP: state_d = cfs_pkg::ST_IDLE;
			cfs_pkg::ST_CALL: begin
				// Two bytes: low then high
				addr_d = sp;
				wdata_d = (cnt_q == 3'h0) ? pc_q[7:0] : pc_q[15:8];
				we_d = 1'b1;
				sp_dec = 1'b1; // RQ12
				cnt_d = cnt_q + 3'h1;
				if (cnt_q == 3'(cfs_pkg::CALL_BYTES - 1)) begin
					pc_d = pc_value;
					state_d = cfs_pkg::ST_IDLE;
				end
			end
			cfs_pkg::ST_RET: begin
				addr_d = sp_next_up;
				re_d = 1'b1;
				sp_inc = 1'b1; // RQ12
				cnt_d = cnt_q + 3'h1;
				if (cnt_q == 3'(cfs_pkg::CALL_BYTES)) begin
					sp_inc = 1'b0;
					re_d = 1'b0;
					// Last byte taken from the read that stands this cycle
					pc_d = {stack_snap[0], stack_rdata}; // RQ14
					state_d = cfs_pkg::ST_IDLE;
				end
			end
			cfs_pkg::ST_IRQ: begin
				// PROG_COUNTER_LOW_BYTE, PROG_COUNTER_HIGH_BYTE, X, A, CC at successively lower addresses; Y untouched
				addr_d = sp; // RQ11
				case (cnt_q)
					3'h0: wdata_d = pc_q[7:0]; // RQ11
					3'h1: wdata_d = pc_q[15:8]; // RQ16
					3'h2: wdata_d = x_value; // RQ16 RQ13
					3'h3: wdata_d = a_value; // RQ16
					default: wdata_d = cc_q; // RQ16 RQ7
				endcase
				we_d = 1'b1;
				sp_dec = 1'b1; // RQ12
				cnt_d = cnt_q + 3'h1;
				if (cnt_q == 3'(cfs_pkg::IRQ_BYTES - 1)) begin
					cc_d[cfs_pkg::CC_MASK_HI_BIT] = vector_priority_setting[1]; // RQ6 RQ5
					cc_d[cfs_pkg::CC_MASK_LO_BIT] = vector_priority_setting[0]; // RQ6 RQ5
					pc_d = vector_addr; // RQ16
					state_d = cfs_pkg::ST_IDLE;
				end
			end
			cfs_pkg::ST_HANDLER_RETURN_OP: begin
				addr_d = sp_next_up;
				re_d = 1'b1;
				sp_inc = 1'b1; // RQ12
				cnt_d = cnt_q + 3'h1;
				if (cnt_q == 3'(cfs_pkg::IRQ_BYTES)) begin
					sp_inc = 1'b0;
					re_d = 1'b0;
					cc_d = stack_snap[0] | cfs_pkg::CC_FIXED_ONES; // RQ16 RQ17
					a_d = stack_snap[1];
					x_d = stack_snap[2];
					xav_d = 1'b1; // RQ13
					pc_d = {stack_snap[3], stack_rdata}; // RQ16
					state_d = cfs_pkg::ST_IDLE;
				end
			end
			default: state_d = cfs_pkg::ST_IDLE;
		endcase
		busy_d = (state_d != cfs_pkg::ST_IDLE);
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			state_q <= cfs_pkg::ST_IDLE;
			cnt_q <= 3'h0;
			cc_q <= cfs_pkg::CC_RESET;
			pc_q <= 16'h0000;
			x_q <= 8'h00;
			a_q <= 8'h00;
			xav_q <= 1'b0;
			addr_q <= cfs_pkg::SP_RESET;
			wdata_q <= 8'h00;
			we_q <= 1'b0;
			re_q <= 1'b0;
			busy_q <= 1'b0;
			for (int i = 0; i < 5; i++) begin
				stack_snap[i] <= 8'h00;
			end
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			cc_q <= cc_d | cfs_pkg::CC_FIXED_ONES; // RQ17
			pc_q <= pc_d;
			x_q <= x_d;
			a_q <= a_d;
			xav_q <= xav_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			we_q <= we_d;
			re_q <= re_d;
			busy_q <= busy_d;
			// Return sequences only; read k lands while cnt_q equals k
			if (re_q && state_q != cfs_pkg::ST_POP) begin
				stack_snap[cnt_q - 3'h1] <= stack_rdata;
			end
		end
	end

	assign condition_code = cc_q;
	assign prog_counter_low_byte = pc_q[7:0];
	assign prog_counter_high_byte = pc_q[15:8];
	assign stack_pointer = sp;
	assign stack_addr = addr_q;
	assign stack_wdata = wdata_q;
	assign stack_we = we_q;
	assign stack_re = re_q;
	assign x_restore = x_q;
	assign a_restore = a_q;
	assign xa_restore_valid = xav_q;
	assign busy = busy_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_fixed_ones;
		@(posedge mclk) disable iff (!resetn) (cc_q & cfs_pkg::CC_FIXED_ONES) == cfs_pkg::CC_FIXED_ONES;
	endproperty
	a_fixed_ones: assert property (p_fixed_ones) else $error("fixed cc bits not one"); // RQ17

	property p_half;
		@(posedge mclk) disable iff (!resetn)
			(state_q == cfs_pkg::ST_IDLE && op == cfs_pkg::OP_ADD && !irq_req) |=> cc_q[4] == $past(alu_half);
	endproperty
	a_half: assert property (p_half) else $error("half carry wrong"); // RQ1

	property p_neg;
		@(posedge mclk) disable iff (!resetn)
			(state_q == cfs_pkg::ST_IDLE && op == cfs_pkg::OP_RESULT && !irq_req) |=> cc_q[2] == $past(result[7]);
	endproperty
	a_neg: assert property (p_neg) else $error("negative flag wrong"); // RQ2

	property p_zero;
		@(posedge mclk) disable iff (!resetn)
			(state_q == cfs_pkg::ST_IDLE && op == cfs_pkg::OP_RESULT && !irq_req) |=> cc_q[1] == ($past(result) == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong"); // RQ3

	property p_setc;
		@(posedge mclk) disable iff (!resetn)
			(state_q == cfs_pkg::ST_IDLE && op == cfs_pkg::OP_SETC && !irq_req) |=> cc_q[0];
	endproperty
	a_setc: assert property (p_setc) else $error("carry not set"); // RQ4

	property p_sp_fixed;
		@(posedge mclk) disable iff (!resetn) sp[15:7] == cfs_pkg::SP_FIXED[15:7];
	endproperty
	a_sp_fixed: assert property (p_sp_fixed) else $error("stack pointer upper bits moved"); // RQ9

	property p_push;
		@(posedge mclk) disable iff (!resetn) we_q |-> stack_addr == $past(sp) && sp[6:0] == $past(sp[6:0]) - 7'h01;
	endproperty
	a_push: assert property (p_push) else $error("push address or decrement wrong"); // RQ8

	property p_irq_len;
		@(posedge mclk) disable iff (!resetn)
			(state_q == cfs_pkg::ST_IDLE && irq_req) |=> (state_q == cfs_pkg::ST_IRQ)[*5] ##1 state_q == cfs_pkg::ST_IDLE;
	endproperty
	a_irq_len: assert property (p_irq_len) else $error("interrupt stacking length wrong"); // RQ12

	property p_irq_first;
		@(posedge mclk) disable iff (!resetn)
			(state_q == cfs_pkg::ST_IDLE && irq_req) |=> ##1 stack_we && stack_wdata == $past(pc_q[7:0]);
	endproperty
	a_irq_first: assert property (p_irq_first) else $error("first stacked byte not pc low"); // RQ11

	property p_irq_mask;
		@(posedge mclk) disable iff (!resetn)
			(state_q == cfs_pkg::ST_IRQ && cnt_q == 3'h4) |=> {cc_q[5], cc_q[3]} == $past(vector_priority_setting);
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("mask not loaded on entry"); // RQ6

	c_irq: cover property (@(posedge mclk) disable iff (!resetn) state_q == cfs_pkg::ST_IRQ ##5 state_q == cfs_pkg::ST_IDLE);
	c_handler_return_op: cover property (@(posedge mclk) disable iff (!resetn) xa_restore_valid);
	c_wrap: cover property (@(posedge mclk) disable iff (!resetn) sp == cfs_pkg::SP_FIXED ##1 sp == cfs_pkg::SP_RESET);
endmodule
`default_nettype wire

// ==== rtl/cfs_stack_ptr.sv ====
// Stack pointer with fixed upper bits and wrap-around
`default_nettype none
module cfs_stack_ptr (
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic        reinit,
	input  wire logic        load,
	input  wire logic [7:0]  load_value,
	input  wire logic        dec,
	input  wire logic        inc,
	output logic      [15:0] sp
);
	logic [6:0] low_q;
	logic [6:0] low_d;

	always_comb begin
		low_d = low_q;
		if (reinit) begin
			low_d = cfs_pkg::SP_RESET[6:0]; // RQ9
		end else if (load) begin
			low_d = load_value[6:0]; // RQ15
		end else if (dec) begin
			low_d = low_q - 7'h01; // RQ10
		end else if (inc) begin
			low_d = low_q + 7'h01; // RQ10
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			low_q <= cfs_pkg::SP_RESET[6:0]; // RQ9
		end else begin
			low_q <= low_d;
		end
	end

	assign sp = cfs_pkg::SP_FIXED | {9'h000, low_q}; // RQ9
endmodule
`default_nettype wire

// ==== testbench/cfs_stack_ram.sv ====
// Stack memory model on the far side of the stack strobes
`default_nettype none
module cfs_stack_ram (
	input  wire logic        mclk,
	input  wire logic [15:0] stack_addr,
	input  wire logic [7:0]  stack_wdata,
	input  wire logic        stack_we,
	input  wire logic        stack_re,
	output logic      [7:0]  stack_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:127];
	logic [7:0] junk_q;
	initial junk_q = 8'h5A;
	// Write on the strobe edge; idle bus toggles so a stray sample shows
	always @(posedge mclk) begin
		if (stack_we)
			mem[stack_addr[6:0]] <= stack_wdata;
		junk_q <= ~junk_q;
	end
	// Read data follows the address while the read strobe stands
	assign stack_rdata = stack_re ? mem[stack_addr[6:0]] : junk_q;
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the flag, program counter and stack block
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// Signals and instances
	// ----------------------------------------------------------------
	cfs_pkg::cfs_op_type op;
	logic        mclk, resetn, alu_carry, alu_half, busy, stack_we, stack_re, xa_restore_valid;
	logic        push_req, pop_req, call_req, ret_req, irq_req, handler_return_op_req;
	logic [1:0]  vector_priority_setting;
	logic [7:0]  result, op_data, x_value, a_value, stack_rdata, condition_code, stack_wdata;
	logic [7:0]  prog_counter_low_byte, prog_counter_high_byte, x_restore, a_restore, xr, ar;
	logic [15:0] pc_value, vector_addr, stack_pointer, stack_addr;
	logic [15:0] wa [$];
	logic [7:0]  wd [$];
	logic [15:0] ra [$];
	int          num_errors, tests_run, nv;
	cfs_regs dut (.mclk, .resetn, .op, .result, .alu_carry, .alu_half, .op_data, .pc_value,
		.push_req, .pop_req, .call_req, .ret_req, .irq_req, .handler_return_op_req, .vector_priority_setting,
		.vector_addr, .x_value, .a_value, .stack_rdata, .condition_code, .prog_counter_low_byte,
		.prog_counter_high_byte, .stack_pointer, .stack_addr, .stack_wdata, .stack_we, .stack_re,
		.x_restore, .a_restore, .xa_restore_valid, .busy);
	cfs_stack_ram ram (.mclk, .stack_addr, .stack_wdata, .stack_we, .stack_re, .stack_rdata);
	initial begin
		mclk = 0;
		forever #2.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		if (stack_we === 1'b1) begin
			wa.push_back(stack_addr);
			wd.push_back(stack_wdata);
		end
		if (stack_re === 1'b1)
			ra.push_back(stack_addr);
		if (xa_restore_valid === 1'b1) begin
			xr = x_restore;
			ar = a_restore;
			nv++;
		end
	end
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic step(input int n = 1);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic settle;
		for (int i = 0; i < 20 && busy !== 1'b0; i++)
			step();
		step(2);
	endtask
	task automatic do_op(input cfs_pkg::cfs_op_type o, input logic [7:0] r, d, input logic c, h);
		op = o;
		result = r;
		op_data = d;
		alu_carry = c;
		alu_half = h;
		step();
		op = cfs_pkg::OP_NONE;
		settle();
	endtask
	task automatic pulse(ref logic r);
		wa.delete();
		wd.delete();
		ra.delete();
		r = 1;
		step();
		r = 0;
		settle();
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		check("cc", condition_code, 8'hE8);
		check("sp", stack_pointer, 16'h017F);
		check("pc", {prog_counter_high_byte, prog_counter_low_byte}, 16'h0000);
		check("busy", busy, 1'b0);
	endtask
	task automatic t_flags;
		do_op(cfs_pkg::OP_ADD, 8'h80, 8'h00, 1, 1);
		check("cc add", condition_code, 8'hFD);
		do_op(cfs_pkg::OP_ADD, 8'h00, 8'h00, 0, 0);
		check("cc add0", condition_code, 8'hEA);
		do_op(cfs_pkg::OP_SETC, 8'h00, 8'h00, 0, 0);
		check("cc setc", condition_code, 8'hEB);
		do_op(cfs_pkg::OP_CLRC, 8'h00, 8'h00, 1, 0);
		check("cc clrc", condition_code, 8'hEA);
		do_op(cfs_pkg::OP_RESULT, 8'h7F, 8'h00, 0, 0);
		check("cc result", condition_code, 8'hE8);
		do_op(cfs_pkg::OP_ARITH, 8'h00, 8'h00, 1, 0);
		check("cc arith", condition_code, 8'hEB);
		do_op(cfs_pkg::OP_SHIFT, 8'h81, 8'h00, 0, 0);
		check("carry shift", condition_code[0], 1'b0);
		do_op(cfs_pkg::OP_MASKR, 8'h00, 8'h00, 0, 0);
		check("mask", {condition_code[5], condition_code[3]}, cfs_pkg::LEVEL0);
		do_op(cfs_pkg::OP_MASKA, 8'h00, 8'h00, 0, 0);
		check("mask", {condition_code[5], condition_code[3]}, cfs_pkg::LEVEL3);
		do_op(cfs_pkg::OP_CCPOP, 8'h00, 8'h00, 0, 0);
		check("cc pop", condition_code, 8'hC0);
		do_op(cfs_pkg::OP_CCPOP, 8'h00, 8'h3F, 0, 0);
		check("cc pop", condition_code, 8'hFF);
	endtask
	task automatic t_stack;
		do_op(cfs_pkg::OP_SPLOAD, 8'h00, 8'hFF, 0, 0);
		check("sp", stack_pointer, 16'h017F);
		do_op(cfs_pkg::OP_SPLOAD, 8'h00, 8'h05, 0, 0);
		check("sp", stack_pointer, 16'h0105);
		do_op(cfs_pkg::OP_SPRST, 8'h00, 8'h00, 0, 0);
		check("sp", stack_pointer, 16'h017F);
		op_data = 8'h3C;
		pulse(push_req);
		check("sp push", stack_pointer, 16'h017E);
		check("push addr", wa[0], 16'h017F);
		check("push data", wd[0], 8'h3C);
		pulse(pop_req);
		check("sp pop", stack_pointer, 16'h017F);
		do_op(cfs_pkg::OP_SPLOAD, 8'h00, 8'h00, 0, 0);
		op_data = 8'h5A;
		pulse(push_req);
		check("sp wrap", stack_pointer, 16'h017F);
		check("push addr", wa[0], 16'h0100);
		pulse(pop_req);
		check("sp wrap", stack_pointer, 16'h0100);
		do_op(cfs_pkg::OP_SPRST, 8'h00, 8'h00, 0, 0);
	endtask
	task automatic t_call;
		pc_value = 16'h1234;
		do_op(cfs_pkg::OP_PCLOAD, 8'h00, 8'h00, 0, 0);
		check("pc", {prog_counter_high_byte, prog_counter_low_byte}, 16'h1234);
		pc_value = 16'hABCD;
		wa.delete();
		call_req = 1;
		step();
		call_req = 0;
		push_req = 1;
		step();
		push_req = 0;
		settle();
		check("sp call", stack_pointer, 16'h017D);
		check("call writes", 16'(wa.size()), 16'd2);
		check("call lo addr", wa[0], 16'h017F);
		check("call lo data", wd[0], 8'h34);
		check("call hi addr", wa[1], 16'h017E);
		check("call hi data", wd[1], 8'h12);
		check("pc", {prog_counter_high_byte, prog_counter_low_byte}, 16'hABCD);
		pulse(ret_req);
		check("pc ret", {prog_counter_high_byte, prog_counter_low_byte}, 16'h1234);
		check("ret reads", 16'(ra.size()), 16'd2);
		check("ret first read", ra[0], 16'h017E);
		check("sp ret", stack_pointer, 16'h017F);
	endtask
	task automatic t_irq;
		logic [7:0] exp [5];
		int nv0;
		exp = '{8'h34, 8'h12, 8'h11, 8'h22, 8'hC1};
		do_op(cfs_pkg::OP_CCPOP, 8'h00, 8'h01, 0, 0);
		x_value = 8'h11;
		a_value = 8'h22;
		vector_priority_setting = cfs_pkg::LEVEL1;
		vector_addr = 16'hF00D;
		pulse(irq_req);
		check("irq writes", 16'(wa.size()), 16'd5);
		for (int i = 0; i < 5; i++) begin
			check("irq addr", wa[i], 16'h017F - 16'(i));
			check("irq data", wd[i], exp[i]);
		end
		check("sp irq", stack_pointer, 16'h017A);
		check("mask irq", {condition_code[5], condition_code[3]}, cfs_pkg::LEVEL1);
		check("pc vec", {prog_counter_high_byte, prog_counter_low_byte}, 16'hF00D);
		x_value = 8'h99;
		a_value = 8'h77;
		nv0 = nv;
		pulse(handler_return_op_req);
		check("restore count", 16'(nv - nv0), 16'd1);
		check("handler_return_op reads", 16'(ra.size()), 16'd5);
		check("handler_return_op first read", ra[0], 16'h017B);
		check("handler_return_op last read", ra[4], 16'h017F);
		check("x restore", xr, 8'h11);
		check("a restore", ar, 8'h22);
		check("cc handler_return_op", condition_code, 8'hC1);
		check("pc handler_return_op", {prog_counter_high_byte, prog_counter_low_byte}, 16'h1234);
		check("sp handler_return_op", stack_pointer, 16'h017F);
		do_op(cfs_pkg::OP_PCINC, 8'h00, 8'h00, 0, 0);
		check("pc inc", {prog_counter_high_byte, prog_counter_low_byte}, 16'h1235);
	endtask
	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		{resetn, alu_carry, alu_half, push_req, pop_req, call_req, ret_req, irq_req, handler_return_op_req} = '0;
		op = cfs_pkg::OP_NONE;
		{result, op_data, x_value, a_value, vector_priority_setting} = '0;
		{pc_value, vector_addr} = '0;
		num_errors = 0;
		tests_run = 0;
		nv = 0;
		step(10);
		resetn = 1;
		step();
		t_reset();
		t_flags();
		t_stack();
		t_call();
		t_irq();
		tally_and_finish();
	end
	initial begin
		#50000;
		num_errors++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
